/* src/lpmc_pkg.sv */
// Operation
// R01 - idle gates cpu clock, peripherals keep running
// R02 - idle only after key then request
// R03 - broken idle sequence clears key or bit
// R04 - interrupt wakes idle, clears key and bit
// R05 - reset in sleep restarts core, clears registers
// R06 - pin, watchdog, low-voltage resets wake sleep
// R07 - sleep entry keeps all cpu state
// R08 - power-down stops all clocks but watchdog; code stops the watchdog too unless the R20 option is set
// R09 - power-down only after key then request
// R10 - broken power-down sequence clears key or bit
// R11 - both bits set selects power-down, clears both
// R12 - external interrupt wakes power-down after warm-up
// R13 - software adds three no-ops after request
// R14 - power control holds request bits 1:0
// R15 - power control holds flag bits, reset zero
// R16 - suspend key is 8-bit, resets zero
// R17 - power warm-up precedes oscillator warm-up
// R18 - oscillator warm-up after resets and power-down; code skips it after a watchdog reset outside power-down unless one is still pending
// R19 - warm-up lengths per cause
// R20 - option keeps watchdog running in power-down
// R21 - internal interrupts cannot wake power-down
package lpmc_pkg;

    localparam int unsigned CLK_HZ       = 50_000_000;
    localparam int unsigned PWR_WARM_MS  = 11;
    localparam int unsigned PWR_WARM_CYC = (CLK_HZ / 1000) * PWR_WARM_MS;
    localparam int unsigned WDT_WARM_CYC = 1000;
    localparam int unsigned IRQ_WARM_CYC = 64;
    localparam int unsigned OSC_WARM_CYC = 8192;
    localparam int unsigned ENTRY_NOPS   = 3;
    localparam int unsigned CNT_W        = 20;
    localparam int unsigned AW           = 12;

    localparam logic [7:0]    IDX_POWER_CONTROL  = 8'h87;
    localparam logic [7:0]    IDX_KEY   = 8'h8e;
    localparam logic [7:0]    IDX_CFG   = 8'h90;
    localparam logic [7:0]    IDX_STAT  = 8'h91;
    localparam logic [AW-1:0] ADDR_POWER_CONTROL = {2'h0, IDX_POWER_CONTROL, 2'h0};
    localparam logic [AW-1:0] ADDR_KEY  = {2'h0, IDX_KEY, 2'h0};
    localparam logic [AW-1:0] ADDR_CFG  = {2'h0, IDX_CFG, 2'h0};
    localparam logic [AW-1:0] ADDR_STAT = {2'h0, IDX_STAT, 2'h0};

    localparam int unsigned PC_IDLE   = 0;
    localparam int unsigned PC_PD     = 1;
    localparam logic [7:0]  PC_WMASK  = 8'hcf;
    localparam logic [7:0]  POWER_CONTROL_RST  = 8'h00;
    localparam logic [7:0]  KEY_RST   = 8'h00;
    localparam logic [7:0]  KEY_VALUE = 8'h55;
    localparam logic [2:0]  CFG_RST   = 3'h0;

    localparam int unsigned CFG_WDT_EN    = 0;
    localparam int unsigned CFG_WDT_SLEEP = 1;
    localparam int unsigned CFG_LVR_EN    = 2;

    localparam logic [15:0] RESTART_ADDR = 16'h0000;

    typedef enum logic [2:0] {
        S_WARM, S_RUN, S_ENTER, S_IDLE, S_PDOWN
    } lpmc_state_t;

    typedef struct packed {
        logic          psel;
        logic          penable;
        logic          pwrite;
        logic [AW-1:0] paddr;
        logic [31:0]   pwdata;
    } lpmc_apb_req_t;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } lpmc_apb_rsp_t;

    typedef struct packed {
        logic [2:0] ext_irq;
        logic       rst_pin;
        logic       wdt_rst;
        logic       lvr_rst;
    } lpmc_pins_t;

    typedef struct packed {
        logic cpu_clk_en;
        logic periph_clk_en;
        logic osc_en;
        logic wdt_run;
        logic core_rst;
        logic irq_resume;
    } lpmc_ctl_t;

endpackage

/* src/lpmc_top.sv */
`timescale 1ns/1ps
module lpmc_top #(
    parameter int unsigned PWR_WARM_CYC_P = lpmc_pkg::PWR_WARM_CYC,
    parameter int unsigned OSC_WARM_CYC_P = lpmc_pkg::OSC_WARM_CYC
) (
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire lpmc_pkg::lpmc_apb_req_t apb_req,
    output      lpmc_pkg::lpmc_apb_rsp_t apb_rsp,
    input  wire lpmc_pkg::lpmc_pins_t    pins,
    input  wire logic                    periph_irq,
    input  wire logic                    insn_step,
    output      lpmc_pkg::lpmc_ctl_t     ctl,
    output      logic [15:0]             restart_addr
);
    import lpmc_pkg::*;

    localparam logic [CNT_W-1:0] PWR_N = CNT_W'(PWR_WARM_CYC_P);
    localparam logic [CNT_W-1:0] OSC_N = CNT_W'(OSC_WARM_CYC_P);
    localparam logic [CNT_W-1:0] WDT_N = CNT_W'(WDT_WARM_CYC);
    localparam logic [CNT_W-1:0] IRQ_N = CNT_W'(IRQ_WARM_CYC);
    localparam logic [CNT_W-1:0] NOP_N = CNT_W'(ENTRY_NOPS);

    lpmc_state_t      state_r;
    lpmc_state_t      state_nxt;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic             osc_pend_r;
    logic             osc_pend_nxt;
    logic             from_rst_r;
    logic             from_rst_nxt;
    logic [7:0]       power_control_r;
    logic [7:0]       key_r;
    logic [2:0]       cfg_r;
    logic             key_armed_r;
    logic             clr_key_r;
    logic             clr_req_r;
    lpmc_apb_rsp_t    rsp_r;
    lpmc_ctl_t        ctl_r;
    logic [5:0]       sync1_r;
    logic [5:0]       sync2_r;
    logic [15:0]      restart_addr_r;

    assign apb_rsp      = rsp_r;
    assign ctl          = ctl_r;
    assign restart_addr = restart_addr_r;

    // restart vector held in a flop so the port is registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            restart_addr_r <= RESTART_ADDR; // R05
        end else begin
            restart_addr_r <= RESTART_ADDR; // R05
        end
    end

    // pin inputs pass two flip-flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_r <= 6'h00;
            sync2_r <= 6'h00;
        end else begin
            sync1_r <= pins;
            sync2_r <= sync1_r;
        end
    end

    logic [2:0] ext_s;
    logic       pin_s;
    logic       wdt_s;
    logic       lvr_s;
    assign ext_s = sync2_r[5:3];
    assign pin_s = sync2_r[2];
    assign wdt_s = sync2_r[1];
    assign lvr_s = sync2_r[0];

    logic ext_any;
    logic irq_any;
    logic wdt_evt;
    logic lvr_evt;
    logic rst_evt;
    assign ext_any = |ext_s;
    assign irq_any = ext_any | periph_irq;
    assign wdt_evt = wdt_s && cfg_r[CFG_WDT_EN]
                     && (state_r != S_PDOWN || cfg_r[CFG_WDT_SLEEP]); // R06 R20
    assign lvr_evt = lvr_s && cfg_r[CFG_LVR_EN]; // R06
    assign rst_evt = pin_s || wdt_evt || lvr_evt; // R06

    // apb decode: access phase is the cycle after setup
    logic setup;
    logic acc;
    logic wr;
    logic hit_power_control;
    logic hit_key;
    logic hit_cfg;
    logic hit_stat;
    logic wr_power_control;
    logic wr_key;
    assign setup    = apb_req.psel && !apb_req.penable;
    assign acc      = apb_req.psel && apb_req.penable && rsp_r.pready;
    assign wr       = acc && apb_req.pwrite && !ctl_r.core_rst;
    assign hit_power_control = apb_req.paddr == ADDR_POWER_CONTROL;
    assign hit_key  = apb_req.paddr == ADDR_KEY;
    assign hit_cfg  = apb_req.paddr == ADDR_CFG;
    assign hit_stat = apb_req.paddr == ADDR_STAT;
    assign wr_power_control  = wr && hit_power_control;
    assign wr_key   = wr && hit_key;

    // instruction boundary: a completed bus write or a core step
    logic step;
    logic req_set;
    logic enter_ok;
    logic bad_step;
    assign step     = insn_step || (acc && apb_req.pwrite);
    assign req_set  = wr_power_control && (apb_req.pwdata[PC_PD] || apb_req.pwdata[PC_IDLE]);
    assign enter_ok = key_armed_r && req_set && state_r == S_RUN; // R02 R09
    assign bad_step = key_armed_r && step && !enter_ok; // R03 R10

    logic [7:0] stat_v;
    assign stat_v = {2'h0, ctl_r.core_rst, ctl_r.wdt_run, key_armed_r,
                     state_r == S_WARM, state_r == S_PDOWN, state_r == S_IDLE};

    logic [31:0] rdata;
    always_comb begin
        rdata = 32'h0000_0000;
        if (hit_power_control) begin
            rdata[7:0] = power_control_r;
        end else if (hit_key) begin
            rdata[7:0] = key_r;
        end else if (hit_cfg) begin
            rdata[2:0] = cfg_r;
        end else if (hit_stat) begin
            rdata[7:0] = stat_v;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rsp_r <= '0;
        end else begin
            rsp_r.pready  <= setup;
            rsp_r.pslverr <= setup && !(hit_power_control || hit_key || hit_cfg || hit_stat);
            rsp_r.prdata  <= setup ? rdata : 32'h0000_0000;
        end
    end

    // sequence tracker: the key write must be the last step before the request
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            key_armed_r <= 1'b0;
            clr_key_r   <= 1'b0;
            clr_req_r   <= 1'b0;
        end else begin
            if (rst_evt || ctl_r.core_rst) begin
                key_armed_r <= 1'b0;
            end else if (wr_key) begin
                key_armed_r <= apb_req.pwdata[7:0] == KEY_VALUE; // R02 R09
            end else if (step) begin
                key_armed_r <= 1'b0;
            end
            clr_key_r <= bad_step; // R03 R10
            clr_req_r <= req_set && !enter_ok; // R03 R10
        end
    end

    logic wake_done;
    assign wake_done = state_r == S_WARM && cnt_r == 1 && !osc_pend_r && !from_rst_r;

    // suspend key register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            key_r <= KEY_RST; // R16
        end else if (rst_evt) begin
            key_r <= KEY_RST; // R05
        end else if (wake_done) begin
            key_r <= KEY_RST; // R04 R12
        end else if (wr_key) begin
            key_r <= apb_req.pwdata[7:0]; // R16
        end else if (clr_key_r) begin
            key_r <= KEY_RST; // R03 R10
        end
    end

    // power control register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            power_control_r <= POWER_CONTROL_RST; // R15
        end else if (rst_evt) begin
            power_control_r <= POWER_CONTROL_RST; // R05 R14
        end else if (wake_done) begin
            power_control_r[PC_PD]   <= 1'b0; // R11 R12 R14
            power_control_r[PC_IDLE] <= 1'b0; // R04 R14
        end else if (wr_power_control) begin
            power_control_r <= apb_req.pwdata[7:0] & PC_WMASK; // R14 R15
        end else if (clr_req_r) begin
            power_control_r[PC_PD]   <= 1'b0; // R10
            power_control_r[PC_IDLE] <= 1'b0; // R03
        end
    end

    // option bits, cleared only by power-on
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_r <= CFG_RST;
        end else if (wr && hit_cfg) begin
            cfg_r <= apb_req.pwdata[2:0]; // R20
        end
    end

    // sequencer
    always_comb begin
        state_nxt    = state_r;
        cnt_nxt      = cnt_r - 1'b1;
        osc_pend_nxt = osc_pend_r;
        from_rst_nxt = from_rst_r;
        case (state_r)
            S_WARM: begin
                if (cnt_r == 1) begin
                    if (osc_pend_r) begin
                        cnt_nxt      = OSC_N; // R17 R18
                        osc_pend_nxt = 1'b0;
                    end else begin
                        state_nxt    = S_RUN;
                        from_rst_nxt = 1'b0;
                    end
                end
            end
            S_RUN: begin
                if (enter_ok) begin
                    state_nxt = S_ENTER; // R02 R09
                    cnt_nxt   = NOP_N; // R13
                end
            end
            S_ENTER: begin
                if (cnt_r == 1) begin
                    if (power_control_r[PC_PD]) begin
                        state_nxt = S_PDOWN; // R09 R11
                    end else begin
                        state_nxt = S_IDLE; // R02
                    end
                end
            end
            S_IDLE: begin
                if (irq_any) begin
                    state_nxt    = S_WARM; // R04
                    cnt_nxt      = IRQ_N; // R19
                    osc_pend_nxt = 1'b0;
                end
            end
            S_PDOWN: begin
                if (ext_any) begin
                    state_nxt    = S_WARM; // R12 R21
                    cnt_nxt      = IRQ_N; // R19
                    osc_pend_nxt = 1'b1; // R18
                end
            end
            default: begin
                state_nxt = S_WARM;
                cnt_nxt   = PWR_N;
            end
        endcase
        if (rst_evt) begin
            state_nxt    = S_WARM; // R05 R06
            from_rst_nxt = 1'b1;
            if (pin_s || lvr_evt) begin
                cnt_nxt      = PWR_N; // R19
                osc_pend_nxt = 1'b1; // R18
            end else begin
                cnt_nxt      = WDT_N; // R19
                // a held level must not forget that it was taken in power-down
                osc_pend_nxt = state_r == S_PDOWN
                               || (state_r == S_WARM && osc_pend_r); // R18 R19
            end
        end
    end

    // power-on starts with the power warm-up, then the oscillator
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r    <= S_WARM;
            cnt_r      <= PWR_N; // R17
            osc_pend_r <= 1'b1; // R17
            from_rst_r <= 1'b1;
        end else begin
            state_r    <= state_nxt;
            cnt_r      <= cnt_nxt;
            osc_pend_r <= osc_pend_nxt;
            from_rst_r <= from_rst_nxt;
        end
    end

    // clock gates follow the next state so they stand with the state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_r.cpu_clk_en    <= 1'b0;
            ctl_r.periph_clk_en <= 1'b0;
            ctl_r.osc_en        <= 1'b1;
            ctl_r.wdt_run       <= 1'b0;
            ctl_r.core_rst      <= 1'b1;
            ctl_r.irq_resume    <= 1'b0;
        end else begin
            ctl_r.cpu_clk_en    <= state_nxt == S_RUN || state_nxt == S_ENTER; // R01 R08
            ctl_r.periph_clk_en <= state_nxt == S_RUN || state_nxt == S_ENTER
                                   || state_nxt == S_IDLE; // R01 R08
            ctl_r.osc_en        <= state_nxt != S_PDOWN; // R08
            ctl_r.wdt_run       <= cfg_r[CFG_WDT_EN]
                                   && (state_nxt != S_PDOWN || cfg_r[CFG_WDT_SLEEP]); // R08 R20
            // sleep entry never touches core reset, so cpu state stays put
            ctl_r.core_rst      <= state_nxt == S_WARM && from_rst_nxt; // R05 R07
            ctl_r.irq_resume    <= wake_done; // R04 R12
        end
    end

    sequence key_then_req_s;
        key_armed_r && enter_ok;
    endsequence

    sequence sleep_in_s;
        state_r == S_ENTER ##1 (state_r == S_IDLE || state_r == S_PDOWN);
    endsequence

    idle_clocks_a: assert property (@(posedge pclk) disable iff (!presetn) // R01
        state_r == S_IDLE |-> !ctl_r.cpu_clk_en && ctl_r.periph_clk_en)
        else $error("idle clock gating wrong");

    entry_key_a: assert property (@(posedge pclk) disable iff (!presetn) // R02
        key_then_req_s |=> state_r == S_ENTER ##3 state_r == S_IDLE || state_r == S_PDOWN
        || state_r == S_WARM)
        else $error("keyed request did not suspend");

    bad_seq_a: assert property (@(posedge pclk) disable iff (!presetn) // R03
        bad_step && !rst_evt |=> clr_key_r && state_r != S_ENTER)
        else $error("broken sequence not cleared");

    idle_wake_a: assert property (@(posedge pclk) disable iff (!presetn) // R04
        state_r == S_IDLE && irq_any && !rst_evt |-> ##[64:66] ctl_r.irq_resume)
        else $error("idle wake timing wrong");

    reset_clear_a: assert property (@(posedge pclk) disable iff (!presetn) // R05
        rst_evt |=> ctl_r.core_rst && power_control_r == POWER_CONTROL_RST && key_r == KEY_RST)
        else $error("reset did not clear");

    keep_state_a: assert property (@(posedge pclk) disable iff (!presetn) // R07
        sleep_in_s |-> !ctl_r.core_rst && $stable(power_control_r[7:2]))
        else $error("sleep entry disturbed state");

    pd_clocks_a: assert property (@(posedge pclk) disable iff (!presetn) // R08
        state_r == S_PDOWN |-> !ctl_r.cpu_clk_en && !ctl_r.periph_clk_en
        && !ctl_r.osc_en)
        else $error("power-down clocks running");

    both_bits_a: assert property (@(posedge pclk) disable iff (!presetn) // R11
        state_r == S_ENTER && power_control_r[PC_PD] && !rst_evt && cnt_r == 1
        |=> state_r == S_PDOWN)
        else $error("power-down not chosen");

    pd_wake_a: assert property (@(posedge pclk) disable iff (!presetn) // R21
        state_r == S_PDOWN && !ext_any && !rst_evt |=> state_r == S_PDOWN)
        else $error("power-down left without cause");

    wdt_sleep_a: assert property (@(posedge pclk) disable iff (!presetn) // R20
        state_r == S_PDOWN |-> ctl_r.wdt_run == (cfg_r[CFG_WDT_EN]
        && cfg_r[CFG_WDT_SLEEP]))
        else $error("watchdog sleep option ignored");

    sequence osc_load_s;
        state_r == S_WARM && cnt_r == 1 && osc_pend_r && !rst_evt;
    endsequence

    sequence wdt_in_pd_s;
        wdt_evt && !pin_s && !lvr_evt && state_r == S_PDOWN;
    endsequence

    pwr_then_osc_a: assert property (@(posedge pclk) disable iff (!presetn) // R17
        osc_load_s |=> state_r == S_WARM && cnt_r == OSC_N && !osc_pend_r)
        else $error("oscillator warm-up not started");

    wdt_pd_osc_a: assert property (@(posedge pclk) disable iff (!presetn) // R18
        wdt_in_pd_s |=> osc_pend_r [*3])
        else $error("watchdog wake lost oscillator warm-up");

    wake_clear_a: assert property (@(posedge pclk) disable iff (!presetn) // R12
        wake_done && !rst_evt |=> key_r == KEY_RST && !power_control_r[PC_PD] && !power_control_r[PC_IDLE]
        && ctl_r.irq_resume && ctl_r.cpu_clk_en)
        else $error("wake did not clear request");

endmodule // lpmc_top

/* test/lpmc_far_model.sv */
`timescale 1ns/1ps
module lpmc_far_model (
    input  wire logic            pclk,
    output lpmc_pkg::lpmc_pins_t pins,
    output logic                 periph_irq,
    output logic                 insn_step
);
    import lpmc_pkg::*;

    // sources: 0..2 ext lines, 3 pin, 4 watchdog, 5 low-voltage, 6 peripheral
    logic [6:0] src_r;
    logic       step_r;

    assign pins       = '{ext_irq: src_r[2:0], rst_pin: src_r[3], wdt_rst: src_r[4],
                          lvr_rst: src_r[5]};
    assign periph_irq = src_r[6];
    assign insn_step  = step_r;

    initial begin
        src_r  = '0;
        step_r = 1'b0;
    end

    // active-high level held for c cycles, then back to the idle low level
    task automatic raise(input int s, input int c);
        src_r[s] <= 1'b1;
        repeat (c) @(posedge pclk);
        src_r[s] <= 1'b0;
    endtask

    // back-to-back no-op completions after a request write
    task automatic nops(input int n);
        step_r <= 1'b1;
        repeat (n) @(posedge pclk);
        step_r <= 1'b0;
    endtask
endmodule // lpmc_far_model

/* test/testbench.sv */
`timescale 1ns/1ps
module testbench;
    import lpmc_pkg::*;

    localparam int PW = 40;
    localparam int OW = 20;

    logic          pclk;
    logic          presetn;
    lpmc_apb_req_t req;
    lpmc_apb_rsp_t rsp;
    lpmc_pins_t    pins;
    logic          periph_irq;
    logic          insn_step;
    lpmc_ctl_t     ctl;
    logic [15:0]   restart_addr;
    logic [5:0]    ctl_w;
    logic [31:0]   rd_v;
    logic          err_v;
    int            n_errors = 0;
    int            cmp_count = 0;

    assign ctl_w = ctl;

    lpmc_top #(.PWR_WARM_CYC_P(PW), .OSC_WARM_CYC_P(OW)) i_lpmc_top (
        .pclk         (pclk),
        .presetn      (presetn),
        .apb_req      (req),
        .apb_rsp      (rsp),
        .pins         (pins),
        .periph_irq   (periph_irq),
        .insn_step    (insn_step),
        .ctl          (ctl),
        .restart_addr (restart_addr)
    );

    lpmc_far_model i_lpmc_far_model (
        .pclk       (pclk),
        .pins       (pins),
        .periph_irq (periph_irq),
        .insn_step  (insn_step)
    );

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    task automatic close_out;
        if (n_errors == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR %0t: got %h expected %h", $time, g, e);
        end
    endtask

    // one apb transfer, then one idle cycle so psel never toggles twice in a step
    task automatic apb(input logic w, input logic [AW-1:0] a, input logic [7:0] d);
        int n;
        n = 0;
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: {24'h0, d}};
        @(posedge pclk);
        req.penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 20);
        if (rsp.pready !== 1'b1) begin
            n_errors++;
            $display("ERROR %0t: no pready", $time);
        end
        rd_v = rsp.prdata;
        err_v = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rd_chk(input logic [AW-1:0] a, input logic [31:0] e);
        apb(1'b0, a, 8'h00);
        chk(rd_v, e);
    endtask

    // bounded wait for one ctl bit: 5 cpu 4 periph 3 osc 2 wdt 1 core_rst 0 resume
    task automatic wait_bit(input int b, input logic v, output int n);
        n = 0;
        while (ctl_w[b] !== v && n < 3000) begin
            @(posedge pclk);
            n++;
        end
        if (ctl_w[b] !== v) begin
            n_errors++;
            $display("ERROR %0t: ctl bit %0d never reached", $time, b);
        end
    endtask

    task automatic sleep_enter(input logic [7:0] r);
        apb(1'b1, ADDR_KEY, KEY_VALUE);
        apb(1'b1, ADDR_POWER_CONTROL, r);
        i_lpmc_far_model.nops(3);
        repeat (3) @(posedge pclk);
    endtask

    task automatic wake(input int s, input int lo, input int hi);
        int n;
        i_lpmc_far_model.raise(s, 5);
        wait_bit(0, 1'b1, n);
        chk(32'(n + 5 >= lo && n + 5 <= hi), 32'h1);
        @(posedge pclk);
        chk(32'(ctl.cpu_clk_en), 32'h1);
        rd_chk(ADDR_POWER_CONTROL, 32'h0);
        rd_chk(ADDR_KEY, 32'h0);
    endtask

    task automatic rst_wake(input logic [7:0] r, input int s, input int lo, input int hi);
        int n;
        sleep_enter(r);
        i_lpmc_far_model.raise(s, 3);
        wait_bit(1, 1'b1, n);
        wait_bit(1, 1'b0, n);
        chk(32'(n >= lo && n <= hi), 32'h1);
        chk({16'h0, restart_addr}, 32'h0);
        rd_chk(ADDR_POWER_CONTROL, 32'h0);
        rd_chk(ADDR_KEY, 32'h0);
    endtask

    task automatic t_regs;
        rd_chk(ADDR_POWER_CONTROL, 32'h0);
        rd_chk(ADDR_KEY, 32'h0);
        apb(1'b1, ADDR_POWER_CONTROL, 8'hfc);
        rd_chk(ADDR_POWER_CONTROL, 32'hcc);
        apb(1'b1, ADDR_KEY, 8'ha5);
        rd_chk(ADDR_KEY, 32'ha5);
        apb(1'b0, 12'h000, 8'h00);
        chk(32'(err_v), 32'h1);
        apb(1'b1, ADDR_POWER_CONTROL, 8'h00);
    endtask

    task automatic t_broken;
        apb(1'b1, ADDR_KEY, KEY_VALUE);
        i_lpmc_far_model.nops(1);
        @(posedge pclk);
        rd_chk(ADDR_KEY, 32'h0);
        apb(1'b1, ADDR_POWER_CONTROL, 8'h01);
        rd_chk(ADDR_POWER_CONTROL, 32'h0);
        apb(1'b1, ADDR_POWER_CONTROL, 8'h02);
        rd_chk(ADDR_POWER_CONTROL, 32'h0);
        chk(32'(ctl.cpu_clk_en), 32'h1);
    endtask

    task automatic t_idle;
        sleep_enter(8'h01);
        chk(32'(ctl.cpu_clk_en), 32'h0);
        chk(32'(ctl.periph_clk_en), 32'h1);
        wake(0, 64, 72);
        sleep_enter(8'h01);
        wake(6, 64, 72);
    endtask

    task automatic t_pdown;
        sleep_enter(8'h03);
        chk({29'h0, ctl_w[5:3]}, 32'h0);
        i_lpmc_far_model.raise(6, 30);
        chk(32'(ctl.cpu_clk_en), 32'h0);
        wake(2, 64 + OW, 72 + OW);
        repeat (10) @(posedge pclk);
        chk(32'(ctl.cpu_clk_en), 32'h1);
    endtask

    task automatic t_resets;
        apb(1'b1, ADDR_CFG, 8'h05);
        rst_wake(8'h01, 3, PW + OW - 4, PW + OW + 8);
        rst_wake(8'h01, 5, PW + OW - 4, PW + OW + 8);
        rst_wake(8'h01, 4, 996, 1008);
        rst_wake(8'h02, 3, PW + OW - 4, PW + OW + 8);
        rd_chk(ADDR_CFG, 32'h5);
    endtask

    task automatic t_wdt_pd;
        apb(1'b1, ADDR_CFG, 8'h01);
        sleep_enter(8'h02);
        chk(32'(ctl.wdt_run), 32'h0);
        i_lpmc_far_model.raise(4, 3);
        repeat (10) @(posedge pclk);
        chk(32'(ctl.core_rst), 32'h0);
        wake(1, 64 + OW, 72 + OW);
        apb(1'b1, ADDR_CFG, 8'h03);
        rst_wake(8'h02, 4, 1000 + OW - 4, 1000 + OW + 8);
    endtask

    initial begin
        #400000;
        n_errors++;
        $display("ERROR %0t: timeout", $time);
        close_out;
    end

    initial begin
        int n;
        presetn = 1'b0;
        req = '0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        wait_bit(1, 1'b0, n);
        chk(32'(n >= PW + OW && n <= PW + OW + 4), 32'h1);
        @(posedge pclk);
        chk({26'h0, ctl_w}, 32'h38);
        t_regs;
        t_broken;
        t_idle;
        t_pdown;
        t_resets;
        t_wdt_pd;
        close_out;
    end
endmodule // testbench
